/* logic/err_report_regs.svh */
// Purpose: Named constants for the error reporting block
// Assumes: Included by the design module and the testbench
// Notes:   Interrupt numbering of the core interrupt controller
`ifndef ERR_REPORT_REGS_SVH
`define ERR_REPORT_REGS_SVH
`define IRQ_LINES       64
`define IRQ_ID_W        6
`define ERR_CLASS_LO    32
`define ERR_CLASS_HI    61
`define IRQ_ENGINE_BASE 0
`define IRQ_PCI         8
`define IRQ_SWITCH      58
`define IRQ_QUEUE       60
`define IRQ_MEMCTL      61
`define IRQ_EXPBUS      62
`define ENGINE_SWITCH   1
`define MC_DATA_W       32
`define MC_CHECK_W      7
`define MC_SYN_W        6
`define MC_CODE_LAST    38
`define MC_LOG_DEPTH    2
`define SW_DATA_W       64
`define SW_PAR_W        8
`define BYTE_W          8
`endif

/* logic/err_report_pkg.sv */
// Purpose: Types shared by the error reporting block
// Assumes: Constants come from err_report_regs.svh
// Notes:   Cause codes for a halted network engine
package err_report_pkg;
  typedef enum logic [1:0] {
    CAUSE_NONE     = 2'b00,
    CAUSE_INTERNAL = 2'b01,
    CAUSE_EXTERNAL = 2'b10
  } cause_e;
endpackage : err_report_pkg

/* logic/parity_ecc_error_reporting.sv */
// Purpose: ECC and parity checking, error capture and error-class interrupt priority
// Assumes: All inputs come from logic on mclk_i; acks are one-cycle pulses
// Notes:   Error flags and the log are sticky until their ack; set wins over ack; hresp, abort and exp_ext_err_o last one cycle
`timescale 1ns/1ps
`include "err_report_regs.svh"
module parity_ecc_error_reporting
  import err_report_pkg::*;
#(
  parameter int ENGINES = 3,
  parameter int ADDR_W  = 32
) (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rstn_i,
  // Memory controller write and read
  input  wire logic                     mc_wr_en_i,
  input  wire logic [`MC_DATA_W-1:0]    mc_wr_data_i,
  output logic      [`MC_CHECK_W-1:0]   mc_wr_check_o,
  input  wire logic                     mc_rd_valid_i,
  input  wire logic [`MC_DATA_W-1:0]    mc_rd_data_i,
  input  wire logic [`MC_CHECK_W-1:0]   mc_rd_check_i,
  input  wire logic [ADDR_W-1:0]        mc_rd_addr_i,
  output logic                          mc_rd_valid_o,
  output logic      [`MC_DATA_W-1:0]    mc_rd_data_o,
  output logic                          mc_hresp_err_o,
  // Memory controller error log
  input  wire logic                     mc_log_ack_i,
  input  wire logic                     mc_ovf_ack_i,
  output logic      [1:0]               mc_log_count_o,
  output logic      [ADDR_W-1:0]        mc_log_addr_o,
  output logic                          mc_log_multi_o,
  output logic                          mc_ovf_o,
  // Switch coprocessor SRAM
  input  wire logic                     sw_wr_en_i,
  input  wire logic [`SW_DATA_W-1:0]    sw_wr_data_i,
  output logic      [`SW_PAR_W-1:0]     sw_wr_par_o,
  input  wire logic                     sw_rd_valid_i,
  input  wire logic [`SW_DATA_W-1:0]    sw_rd_data_i,
  input  wire logic [`SW_PAR_W-1:0]     sw_rd_par_i,
  input  wire logic                     sw_ack_i,
  output logic                          sw_err_o,
  // Network engines
  input  wire logic [ENGINES-1:0]       eng_engine_instruction_memory_err_i,
  input  wire logic [ENGINES-1:0]       eng_engine_data_memory_err_i,
  input  wire logic [ENGINES-1:0]       eng_cop_err_i,
  input  wire logic [ENGINES-1:0]       eng_ahbcop_resp_err_i,
  input  wire logic [ENGINES-1:0]       eng_ack_i,
  output logic      [ENGINES-1:0]       eng_halt_o,
  output logic      [ENGINES-1:0]       eng_port_en_o,
  output logic      [ENGINES-1:0]       eng_ahbcop_abort_o,
  output cause_e                        eng_cause_o [ENGINES],
  // Queue manager
  input  wire logic                     qm_rd_valid_i,
  input  wire logic                     qm_par_err_i,
  input  wire logic                     qm_is_cfg_i,
  input  wire logic [ADDR_W-1:0]        qm_addr_i,
  input  wire logic                     qm_ack_i,
  output logic                          qm_hresp_err_o,
  output logic                          qm_err_o,
  output logic                          qm_err_cfg_o,
  output logic      [ADDR_W-1:0]        qm_err_addr_o,
  // Expansion bus
  input  wire logic                     exp_par_err_i,
  input  wire logic                     exp_outbound_rd_i,
  input  wire logic                     exp_inbound_wr_i,
  input  wire logic [ADDR_W-1:0]        exp_addr_i,
  input  wire logic                     exp_ack_i,
  output logic                          exp_hresp_err_o,
  output logic                          exp_ext_err_o,
  output logic                          exp_err_o,
  output logic      [ADDR_W-1:0]        exp_err_addr_o,
  // PCI controller
  input  wire logic                     pci_par_err_i,
  input  wire logic                     pci_from_ahb_i,
  input  wire logic                     pci_write_i,
  input  wire logic                     pci_ack_i,
  output logic                          pci_err_o,
  // AHB-AHB bridge
  input  wire logic                     south_hresp_err_i,
  output logic                          north_hresp_err_o,
  // Core interrupt
  output logic                          irq_o,
  output logic                          irq_err_class_o,
  output logic      [`IRQ_ID_W-1:0]     irq_id_o
);

  function automatic logic [`MC_CHECK_W-1:0] ecc_gen(input logic [`MC_DATA_W-1:0] d);
    logic [`MC_SYN_W-1:0] h;
    int k;
    h = '0;
    k = 0;
    for (int p = 1; p <= `MC_CODE_LAST; p++) begin
      if ((p & (p - 1)) != 0) begin
        h = h ^ ({`MC_SYN_W{d[k]}} & p[`MC_SYN_W-1:0]);
        k++;
      end
    end
    return {(^d) ^ (^h), h};
  endfunction : ecc_gen

  function automatic logic [`MC_DATA_W-1:0] ecc_fix(input logic [`MC_DATA_W-1:0] d,
                                                     input logic [`MC_SYN_W-1:0]  syn);
    logic [`MC_DATA_W-1:0] r;
    int k;
    r = d;
    k = 0;
    for (int p = 1; p <= `MC_CODE_LAST; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (p[`MC_SYN_W-1:0] == syn) r[k] = ~r[k];
        k++;
      end
    end
    return r;
  endfunction : ecc_fix

  function automatic logic [`SW_PAR_W-1:0] byte_par(input logic [`SW_DATA_W-1:0] d);
    logic [`SW_PAR_W-1:0] r;
    r = '0;
    for (int b = 0; b < `SW_PAR_W; b++) r[b] = ^d[b*`BYTE_W +: `BYTE_W];
    return r;
  endfunction : byte_par

  // Memory controller checker
  logic [`MC_CHECK_W-1:0] mc_diff;
  logic                   mc_single, mc_multi, mc_ovl;
  logic [`MC_CHECK_W-1:0] mc_wr_check_d;
  logic [`MC_DATA_W-1:0]  mc_rd_data_d;
  logic                   mc_rd_valid_d, mc_hresp_err_d;
  logic [1:0]             cnt_q, cnt_d;
  logic [ADDR_W-1:0]      addr_q [`MC_LOG_DEPTH], addr_d [`MC_LOG_DEPTH];
  logic [`MC_LOG_DEPTH-1:0] multi_q, multi_d;
  logic                   ovf_q, ovf_d;
  logic [1:0]             cnt_pop;

  always_comb begin
    mc_diff        = ecc_gen(mc_rd_data_i) ^ mc_rd_check_i;
    // Overall parity must span the stored Hamming bits, not the recomputed ones
    mc_ovl         = mc_diff[`MC_CHECK_W-1] ^ (^mc_diff[`MC_SYN_W-1:0]);
    mc_single      = mc_rd_valid_i && mc_ovl;
    mc_multi       = mc_rd_valid_i && !mc_ovl && (mc_diff[`MC_SYN_W-1:0] != '0);
    mc_wr_check_d  = mc_wr_en_i ? ecc_gen(mc_wr_data_i) : mc_wr_check_o;
    mc_rd_valid_d  = mc_rd_valid_i;
    // Corrected copy goes out only; memory keeps the bad bit until software rewrites it
    mc_rd_data_d   = mc_single ? ecc_fix(mc_rd_data_i, mc_diff[`MC_SYN_W-1:0]) : mc_rd_data_i;
    mc_hresp_err_d = mc_multi;
    // Log is a two-deep queue; ack pops the head first so a same-cycle error fits
    cnt_pop = (mc_log_ack_i && cnt_q != 2'h0) ? cnt_q - 2'h1 : cnt_q;
    addr_d  = addr_q;
    multi_d = multi_q;
    if (mc_log_ack_i && cnt_q != 2'h0) begin
      addr_d[0]  = addr_q[1];
      multi_d[0] = multi_q[1];
    end
    cnt_d = cnt_pop;
    ovf_d = ovf_q && !mc_ovf_ack_i;
    if (mc_single || mc_multi) begin
      if (cnt_pop < 2'(`MC_LOG_DEPTH)) begin
        addr_d[cnt_pop[0]]  = mc_rd_addr_i;
        multi_d[cnt_pop[0]] = mc_multi;
        cnt_d               = cnt_pop + 2'h1;
      end else begin
        ovf_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      mc_wr_check_o  <= '0;
      mc_rd_valid_o  <= 1'b0;
      mc_rd_data_o   <= '0;
      mc_hresp_err_o <= 1'b0;
      cnt_q          <= 2'h0;
      addr_q         <= '{default: '0};
      multi_q        <= '0;
      ovf_q          <= 1'b0;
    end else begin
      mc_wr_check_o  <= mc_wr_check_d;
      mc_rd_valid_o  <= mc_rd_valid_d;
      mc_rd_data_o   <= mc_rd_data_d;
      mc_hresp_err_o <= mc_hresp_err_d;
      cnt_q          <= cnt_d;
      addr_q         <= addr_d;
      multi_q        <= multi_d;
      ovf_q          <= ovf_d;
    end
  end

  assign mc_log_count_o = cnt_q;
  assign mc_log_addr_o  = addr_q[0];
  assign mc_log_multi_o = multi_q[0];
  assign mc_ovf_o       = ovf_q;

  // Switch coprocessor, queue manager, expansion bus, PCI and bridge flags
  logic                 sw_mis;
  logic [`SW_PAR_W-1:0] sw_wr_par_d;
  logic                 sw_err_d, qm_hit, qm_hresp_d, qm_err_d, qm_cfg_d;
  logic [ADDR_W-1:0]    qm_addr_d, exp_addr_d;
  logic                 exp_hit, exp_hresp_d, exp_ext_d, exp_err_d, pci_hit, pci_err_d, north_d;

  always_comb begin
    sw_wr_par_d = sw_wr_en_i ? byte_par(sw_wr_data_i) : sw_wr_par_o;
    sw_mis      = sw_rd_valid_i && (byte_par(sw_rd_data_i) != sw_rd_par_i);
    sw_err_d    = sw_mis || (sw_err_o && !sw_ack_i);
    qm_hit      = qm_rd_valid_i && qm_par_err_i;
    qm_hresp_d  = qm_hit;
    qm_err_d    = qm_hit || (qm_err_o && !qm_ack_i);
    qm_cfg_d    = qm_hit ? qm_is_cfg_i : qm_err_cfg_o;
    qm_addr_d   = qm_hit ? qm_addr_i : qm_err_addr_o;
    exp_hit     = exp_par_err_i && (exp_outbound_rd_i || exp_inbound_wr_i);
    exp_hresp_d = exp_par_err_i && exp_outbound_rd_i;
    exp_ext_d   = exp_par_err_i && exp_inbound_wr_i;
    exp_err_d   = exp_hit || (exp_err_o && !exp_ack_i);
    exp_addr_d  = exp_hit ? exp_addr_i : exp_err_addr_o;
    // Reads from PCI into AHB are checked by the memory controller instead
    pci_hit     = pci_par_err_i && (pci_from_ahb_i || pci_write_i);
    pci_err_d   = pci_hit || (pci_err_o && !pci_ack_i);
    north_d     = south_hresp_err_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sw_wr_par_o       <= '0;
      sw_err_o          <= 1'b0;
      qm_hresp_err_o    <= 1'b0;
      qm_err_o          <= 1'b0;
      qm_err_cfg_o      <= 1'b0;
      qm_err_addr_o     <= '0;
      exp_hresp_err_o   <= 1'b0;
      exp_ext_err_o     <= 1'b0;
      exp_err_o         <= 1'b0;
      exp_err_addr_o    <= '0;
      pci_err_o         <= 1'b0;
      north_hresp_err_o <= 1'b0;
    end else begin
      sw_wr_par_o       <= sw_wr_par_d;
      sw_err_o          <= sw_err_d;
      qm_hresp_err_o    <= qm_hresp_d;
      qm_err_o          <= qm_err_d;
      qm_err_cfg_o      <= qm_cfg_d;
      qm_err_addr_o     <= qm_addr_d;
      exp_hresp_err_o   <= exp_hresp_d;
      exp_ext_err_o     <= exp_ext_d;
      exp_err_o         <= exp_err_d;
      exp_err_addr_o    <= exp_addr_d;
      pci_err_o         <= pci_err_d;
      north_hresp_err_o <= north_d;
    end
  end

  // Network engines
  for (genvar n = 0; n < ENGINES; n++) begin : g_eng
    logic   int_ev, ext_ev, halt_d, abort_d;
    cause_e cause_q, cause_d;
    always_comb begin
      int_ev  = eng_engine_instruction_memory_err_i[n] || eng_engine_data_memory_err_i[n];
      ext_ev  = eng_cop_err_i[n] || eng_ahbcop_resp_err_i[n] ||
                (n == `ENGINE_SWITCH && sw_mis);
      abort_d = eng_ahbcop_resp_err_i[n];
      halt_d  = int_ev || ext_ev || (eng_halt_o[n] && !eng_ack_i[n]);
      cause_d = cause_q;
      // First cause is kept while halted; a new event after ack overwrites
      if (!eng_halt_o[n] || eng_ack_i[n]) begin
        cause_d = int_ev ? CAUSE_INTERNAL : (ext_ev ? CAUSE_EXTERNAL : CAUSE_NONE);
      end
    end
    always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
        eng_halt_o[n]         <= 1'b0;
        eng_ahbcop_abort_o[n] <= 1'b0;
        cause_q               <= CAUSE_NONE;
      end else begin
        eng_halt_o[n]         <= halt_d;
        eng_ahbcop_abort_o[n] <= abort_d;
        cause_q               <= cause_d;
      end
    end
    assign eng_port_en_o[n] = !eng_halt_o[n];
    assign eng_cause_o[n]   = cause_q;
  end

  // Interrupt lines and priority
  logic [`IRQ_LINES-1:0] lines;
  logic                  irq_d, cls_d;
  logic [`IRQ_ID_W-1:0]  id_d;

  always_comb begin
    lines = '0;
    for (int n = 0; n < ENGINES; n++) lines[`IRQ_ENGINE_BASE + n] = eng_halt_o[n];
    lines[`IRQ_PCI]    = pci_err_o;
    lines[`IRQ_SWITCH] = sw_err_o;
    lines[`IRQ_QUEUE]  = qm_err_o;
    lines[`IRQ_MEMCTL] = (cnt_q != 2'h0) || ovf_q;
    lines[`IRQ_EXPBUS] = exp_err_o;
    irq_d = |lines;
    cls_d = |lines[`ERR_CLASS_HI:`ERR_CLASS_LO];
    id_d  = '0;
    // Scan downward so the lowest pending line of the winning class is kept
    if (cls_d) begin
      for (int i = `ERR_CLASS_HI; i >= `ERR_CLASS_LO; i--) if (lines[i]) id_d = `IRQ_ID_W'(i);
    end else begin
      for (int i = `IRQ_LINES - 1; i >= 0; i--) begin
        if (lines[i] && (i < `ERR_CLASS_LO || i > `ERR_CLASS_HI)) id_d = `IRQ_ID_W'(i);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_o           <= 1'b0;
      irq_err_class_o <= 1'b0;
      irq_id_o        <= '0;
    end else begin
      irq_o           <= irq_d;
      irq_err_class_o <= cls_d;
      irq_id_o        <= id_d;
    end
  end

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_sw_detect;
    sw_rd_valid_i && (byte_par(sw_rd_data_i) != sw_rd_par_i);
  endsequence
  sequence s_sw_report;
    sw_err_o && eng_halt_o[`ENGINE_SWITCH];
  endsequence

  property p_mc_wr_check;
    mc_wr_en_i |=> mc_wr_check_o == ecc_gen($past(mc_wr_data_i));
  endproperty
  a_mc_wr_check: assert property (p_mc_wr_check) else $error("check bits not stored");
  property p_mc_clean_read;
    mc_rd_valid_i && ecc_gen(mc_rd_data_i) == mc_rd_check_i
      |=> mc_rd_valid_o && !mc_hresp_err_o && mc_rd_data_o == $past(mc_rd_data_i);
  endproperty
  a_mc_clean_read: assert property (p_mc_clean_read) else $error("clean read altered");
  property p_mc_multi;
    mc_multi |=> mc_hresp_err_o && mc_rd_data_o == $past(mc_rd_data_i);
  endproperty
  a_mc_multi: assert property (p_mc_multi) else $error("multi-bit error not answered");
  property p_mc_log;
    (mc_single || mc_multi) && cnt_q == 2'h0 |=> cnt_q == 2'h1 && mc_log_addr_o == $past(mc_rd_addr_i) ##1 irq_o;
  endproperty
  a_mc_log: assert property (p_mc_log) else $error("error not logged");
  property p_mc_ovf;
    (mc_single || mc_multi) && cnt_q == 2'h2 && !mc_log_ack_i |=> mc_ovf_o && cnt_q == 2'h2;
  endproperty
  a_mc_ovf: assert property (p_mc_ovf) else $error("overflow not flagged");
  property p_sw_par;
    sw_wr_en_i |=> sw_wr_par_o == byte_par($past(sw_wr_data_i));
  endproperty
  a_sw_par: assert property (p_sw_par) else $error("byte parity not stored");
  property p_sw_report;
    s_sw_detect |=> s_sw_report;
  endproperty
  a_sw_report: assert property (p_sw_report) else $error("switch parity not reported");
  property p_eng_internal;
    eng_engine_instruction_memory_err_i[0] && !eng_halt_o[0] |=> eng_halt_o[0] && !eng_port_en_o[0] && eng_cause_o[0] == CAUSE_INTERNAL;
  endproperty
  a_eng_internal: assert property (p_eng_internal) else $error("engine did not halt");
  property p_qm_resp;
    qm_rd_valid_i && qm_par_err_i |=> qm_hresp_err_o && qm_err_addr_o == $past(qm_addr_i);
  endproperty
  a_qm_resp: assert property (p_qm_resp) else $error("queue error not answered");
  property p_err_class;
    sw_err_o |=> irq_err_class_o && irq_id_o <= `IRQ_ID_W'(`ERR_CLASS_HI);
  endproperty
  a_err_class: assert property (p_err_class) else $error("error class not preferred");

endmodule : parity_ecc_error_reporting

/* sim/ddr_model.sv */
// Purpose: External memory beside the memory controller, data plus check bits
// Assumes: Check bits arrive one cycle after the write strobe
// Notes:   Idle read bus shows the inverse of the last value, never a held copy
`timescale 1ns/1ps
module ddr_model (
  // Write side
  input  wire logic        clk_i,
  input  wire logic        wr_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [6:0]  wcheck_i,
  // Read side
  input  wire logic        rd_i,
  input  wire logic [38:0] flip_i,
  input  wire logic [1:0]  lat_i,
  output logic             rd_valid_o,
  output logic      [31:0] rdata_o,
  output logic      [6:0]  rcheck_o,
  output logic      [3:0]  raddr_o
);
  logic [31:0] mem_d [16];
  logic [6:0]  mem_c [16];
  logic [3:0]  wa_q, ra_q;
  logic [1:0]  cnt_q;
  logic        pend_q, busy_q;
  initial begin
    {pend_q, busy_q, rd_valid_o, rdata_o, rcheck_o, raddr_o} = '0;
  end
  always @(posedge clk_i) begin
    pend_q <= wr_i;
    wa_q <= addr_i;
    if (wr_i) mem_d[addr_i] <= wdata_i;
    if (pend_q) mem_c[wa_q] <= wcheck_i;
    rd_valid_o <= 1'b0;
    rdata_o <= ~rdata_o;
    rcheck_o <= ~rcheck_o;
    // Reads never write back: a corrected word stays bad here
    if (rd_i && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= lat_i;
      ra_q <= addr_i;
    end else if (busy_q && cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      rd_valid_o <= 1'b1;
      rdata_o <= mem_d[ra_q] ^ flip_i[31:0];
      rcheck_o <= mem_c[ra_q] ^ flip_i[38:32];
      raddr_o <= ra_q;
    end
  end
endmodule : ddr_model

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the error reporting block
// Assumes: Inputs change on the falling edge of mclk_i
// Notes:   Fixed-seed xorshift stimulus; expectations from bench functions
`timescale 1ns/1ps
`include "err_report_regs.svh"
module tb_top;
  import err_report_pkg::*;
  logic        mclk_i, rstn_i, mc_wr_en_i, mc_rd_valid_i, mc_rd_valid_o, mc_hresp_err_o;
  logic        mc_log_ack_i, mc_ovf_ack_i, mc_log_multi_o, mc_ovf_o, m_rd;
  logic [31:0] mc_wr_data_i, mc_rd_data_i, mc_rd_data_o, mc_rd_addr_i, mc_log_addr_o;
  logic [6:0]  mc_wr_check_o, mc_rd_check_i;
  logic [1:0]  mc_log_count_o, m_lat;
  logic [3:0]  m_addr, m_raddr;
  logic [38:0] m_flip;
  logic        sw_wr_en_i, sw_rd_valid_i, sw_ack_i, sw_err_o;
  logic [63:0] sw_wr_data_i, sw_rd_data_i;
  logic [7:0]  sw_wr_par_o, sw_rd_par_i;
  logic [2:0]  eng_engine_instruction_memory_err_i, eng_engine_data_memory_err_i, eng_cop_err_i, eng_ahbcop_resp_err_i, eng_ack_i;
  logic [2:0]  eng_halt_o, eng_port_en_o, eng_ahbcop_abort_o;
  cause_e      eng_cause_o [3];
  logic        qm_rd_valid_i, qm_par_err_i, qm_is_cfg_i, qm_ack_i, qm_hresp_err_o, qm_err_o, qm_err_cfg_o;
  logic [31:0] qm_addr_i, qm_err_addr_o, exp_addr_i, exp_err_addr_o;
  logic        exp_par_err_i, exp_outbound_rd_i, exp_inbound_wr_i, exp_ack_i;
  logic        exp_hresp_err_o, exp_ext_err_o, exp_err_o;
  logic        pci_par_err_i, pci_from_ahb_i, pci_write_i, pci_ack_i, pci_err_o;
  logic        south_hresp_err_i, north_hresp_err_o, irq_o, irq_err_class_o;
  logic [5:0]  irq_id_o;
  logic [31:0] seed, exp_mem [16], d;
  logic [63:0] d64;
  int          num_errors, n_compared;

  assign mc_rd_addr_i = {28'h0, m_raddr};
  parity_ecc_error_reporting #(.ENGINES(3), .ADDR_W(32)) uut (.*);
  ddr_model mem (.clk_i(mclk_i), .wr_i(mc_wr_en_i), .addr_i(m_addr), .wdata_i(mc_wr_data_i),
    .wcheck_i(mc_wr_check_o), .rd_i(m_rd), .flip_i(m_flip), .lat_i(m_lat), .rd_valid_o(mc_rd_valid_i),
    .rdata_o(mc_rd_data_i), .rcheck_o(mc_rd_check_i), .raddr_o(m_raddr));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Hamming over positions 1..38, overall parity on top
  function automatic logic [6:0] ecc(input logic [31:0] v);
    logic [5:0] h;
    int k;
    h = '0;
    k = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int i = 0; i < 6; i++) if (p[i]) h[i] ^= v[k];
        k++;
      end
    end
    return {^v ^ ^h, h};
  endfunction : ecc

  function automatic logic [7:0] bpar(input logic [63:0] v);
    for (int b = 0; b < 8; b++) bpar[b] = ^v[8*b +: 8];
  endfunction : bpar

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(negedge mclk_i);
    {m_addr, mc_wr_data_i, mc_wr_en_i} = {a, v, 1'b1};
    @(negedge mclk_i);
    mc_wr_en_i = 1'b0;
    exp_mem[a] = v;
    chk("mc_wr_check_o", mc_wr_check_o, ecc(v));
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [38:0] f, input logic [1:0] l, input logic e);
    int t;
    @(negedge mclk_i);
    {m_addr, m_flip, m_lat, m_rd} = {a, f, l, 1'b1};
    @(negedge mclk_i);
    m_rd = 1'b0;
    t = 0;
    while (mc_rd_valid_o !== 1'b1 && t < 10) begin
      @(negedge mclk_i);
      t++;
    end
    chk("mc_rd_valid_o", mc_rd_valid_o, 1);
    if (!e) chk("mc_rd_data_o", mc_rd_data_o, exp_mem[a]);
    chk("mc_hresp_err_o", mc_hresp_err_o, e);
  endtask : rd

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    finish_test();
  end

  initial begin
    seed = 32'h6788F79B;
    {num_errors, n_compared} = '0;
    {rstn_i, mc_wr_en_i, mc_log_ack_i, mc_ovf_ack_i, m_rd, m_addr, m_flip, m_lat} = '0;
    {sw_wr_en_i, sw_rd_valid_i, sw_ack_i, sw_wr_data_i, sw_rd_data_i, sw_rd_par_i, mc_wr_data_i} = '0;
    {eng_engine_instruction_memory_err_i, eng_engine_data_memory_err_i, eng_cop_err_i, eng_ahbcop_resp_err_i, eng_ack_i} = '0;
    {qm_rd_valid_i, qm_par_err_i, qm_is_cfg_i, qm_ack_i, qm_addr_i, exp_addr_i} = '0;
    {exp_par_err_i, exp_outbound_rd_i, exp_inbound_wr_i, exp_ack_i} = '0;
    {pci_par_err_i, pci_from_ahb_i, pci_write_i, pci_ack_i, south_hresp_err_i} = '0;
    repeat (4) @(negedge mclk_i);
    rstn_i = 1'b1;
    // Clean traffic, random data and latency
    for (int i = 0; i < 8; i++) begin
      wr(i[3:0], rnd());
      rd(i[3:0], '0, rnd() % 4, 1'b0);
      chk("mc_log_count_o", mc_log_count_o, 0);
    end
    rd(4'h1, 39'h1 << (rnd() % 32), 2'h1, 1'b0);
    chk("mc_log_count_o", mc_log_count_o, 1);
    rd(4'h2, 39'h3 << (rnd() % 30), 2'h0, 1'b1);
    chk("mc_log_count_o", mc_log_count_o, 2);
    rd(4'h3, 39'h1 << (32 + rnd() % 7), 2'h3, 1'b0);
    @(negedge mclk_i);
    chk("mc_log_count_o", mc_log_count_o, 2);
    chk("mc_ovf_o", mc_ovf_o, 1);
    chk("mc_log_addr_o", {mc_log_multi_o, mc_log_addr_o}, 33'h1);
    chk("irq_id_o", {irq_o, irq_err_class_o, irq_id_o}, {2'b11, 6'd61});
    @(negedge mclk_i);
    eng_engine_instruction_memory_err_i = 3'h1;
    @(negedge mclk_i);
    eng_engine_instruction_memory_err_i = 3'h0;
    repeat (2) @(negedge mclk_i);
    chk("irq_id_o", irq_id_o, 61);
    mc_log_ack_i = 1'b1;
    @(negedge mclk_i);
    mc_log_ack_i = 1'b0;
    chk("mc_log_addr_o", {mc_log_multi_o, mc_log_count_o, mc_log_addr_o}, {3'b101, 32'h2});
    {mc_log_ack_i, mc_ovf_ack_i} = 2'b11;
    @(negedge mclk_i);
    {mc_log_ack_i, mc_ovf_ack_i} = 2'b00;
    repeat (2) @(negedge mclk_i);
    chk("mc_ovf_o", {mc_ovf_o, mc_log_count_o}, 0);
    chk("irq_id_o", {irq_o, irq_err_class_o, irq_id_o}, {2'b10, 6'd0});
    chk("eng_halt_o", eng_halt_o, 3'h1);
    // Every engine cause: engine_instruction_memory, engine_data_memory, coprocessor, bridged bus error
    for (int k = 0; k < 4; k++) begin
      eng_ack_i = 3'h7;
      @(negedge mclk_i);
      eng_ack_i = 3'h0;
      chk("eng_halt_o", eng_halt_o, 0);
      {eng_ahbcop_resp_err_i, eng_cop_err_i, eng_engine_data_memory_err_i, eng_engine_instruction_memory_err_i} = 12'h1 << (4 * k - k / 3 * 3);
      @(negedge mclk_i);
      {eng_ahbcop_resp_err_i, eng_cop_err_i, eng_engine_data_memory_err_i, eng_engine_instruction_memory_err_i} = '0;
      chk("eng_halt_o", {eng_halt_o, eng_port_en_o}, {3'h1 << (k % 3), ~(3'h1 << (k % 3))});
      chk("eng_cause_o", eng_cause_o[k % 3], (k < 2) ? CAUSE_INTERNAL : CAUSE_EXTERNAL);
      chk("eng_ahbcop_abort_o", eng_ahbcop_abort_o[0], k == 3);
    end
    // Switch SRAM: clean read, then one byte with bad parity
    d64 = {rnd(), rnd()};
    {eng_ack_i, sw_wr_data_i, sw_wr_en_i} = {3'h7, d64, 1'b1};
    @(negedge mclk_i);
    {eng_ack_i, sw_wr_en_i} = '0;
    chk("sw_wr_par_o", sw_wr_par_o, bpar(d64));
    for (int j = 0; j < 2; j++) begin
      {sw_rd_data_i, sw_rd_par_i, sw_rd_valid_i} = {d64, bpar(d64) ^ (8'(j) << (rnd() % 8)), 1'b1};
      @(negedge mclk_i);
      sw_rd_valid_i = 1'b0;
      chk("sw_err_o", {sw_err_o, eng_halt_o[1]}, {2{j[0]}});
    end
    chk("eng_cause_o", eng_cause_o[1], CAUSE_EXTERNAL);
    @(negedge mclk_i);
    chk("irq_id_o", {irq_err_class_o, irq_id_o}, {1'b1, 6'd58});
    {sw_ack_i, eng_ack_i} = 4'hF;
    // Queue manager, random entry kind and address
    d = rnd();
    {qm_rd_valid_i, qm_par_err_i, qm_is_cfg_i, qm_addr_i} = {2'b11, d[0], d};
    @(negedge mclk_i);
    {sw_ack_i, eng_ack_i, qm_rd_valid_i, qm_par_err_i} = '0;
    chk("qm_hresp_err_o", {qm_hresp_err_o, qm_err_o}, 2'b11);
    chk("qm_err_addr_o", {qm_err_cfg_o, qm_err_addr_o}, {d[0], d});
    @(negedge mclk_i);
    chk("qm_hresp_err_o", {qm_hresp_err_o, qm_err_o, irq_id_o}, {2'b01, 6'd60});
    qm_ack_i = 1'b1;
    // Expansion bus: outbound read, then inbound write
    for (int j = 0; j < 2; j++) begin
      d = rnd();
      @(negedge mclk_i);
      {qm_ack_i, exp_ack_i} = '0;
      {exp_par_err_i, exp_outbound_rd_i, exp_inbound_wr_i, exp_addr_i} = {1'b1, j == 0, j == 1, d};
      @(negedge mclk_i);
      {exp_par_err_i, exp_outbound_rd_i, exp_inbound_wr_i, exp_ack_i} = 4'h1;
      chk("exp_hresp_err_o", {exp_hresp_err_o, exp_ext_err_o, exp_err_o}, {j == 0, j == 1, 1'b1});
      chk("exp_err_addr_o", exp_err_addr_o, d);
    end
    // PCI: every direction and kind
    for (int j = 0; j < 4; j++) begin
      @(negedge mclk_i);
      {exp_ack_i, pci_ack_i} = '0;
      {pci_par_err_i, pci_from_ahb_i, pci_write_i} = {1'b1, j[0], j[1]};
      @(negedge mclk_i);
      {pci_par_err_i, pci_ack_i} = 2'b01;
      chk("pci_err_o", pci_err_o, j != 0);
    end
    pci_ack_i = 1'b0;
    south_hresp_err_i = 1'b1;
    @(negedge mclk_i);
    south_hresp_err_i = 1'b0;
    chk("north_hresp_err_o", north_hresp_err_o, 1);
    @(negedge mclk_i);
    chk("north_hresp_err_o", north_hresp_err_o, 0);
    finish_test();
  end
endmodule : tb_top
